// >>> verilog/irqb_pkg.sv
package irqb_pkg;

   localparam int          DATA_W            = 8;
   localparam int          ADDR_W            = 8;

   // Register offsets on the plain register port.
   localparam logic [7:0]  ADDR_REQ_FIRST    = 8'h06;
   localparam logic [7:0]  ADDR_REQ_SECOND   = 8'h07;
   localparam logic [7:0]  ADDR_EN_FIRST     = 8'h08;
   localparam logic [7:0]  ADDR_EN_SECOND    = 8'h09;

   // Mode bit position shared by both request registers, and their flag widths.
   localparam int          MODE_BIT          = 7;
   localparam int          FIRST_FLAGS_W     = 7;
   localparam int          SECOND_FLAGS_W    = 6;

   // First request register.
   localparam int          HIGH_WM_BIT       = 6;
   localparam int          LOW_WM_BIT        = 5;
   localparam int          CMD_END_BIT       = 4;
   localparam int          TX_DONE_BIT       = 3;
   localparam int          RX_END_BIT        = 2;
   localparam int          ERROR_BIT         = 1;
   localparam int          FRAME_START_BIT   = 0;

   // Second request register.
   localparam int          GLOBAL_BIT        = 6;
   localparam int          CARD_DETECT_BIT   = 5;
   localparam int          TIMER_LOW_BIT     = 0;
   localparam int          TIMER_COUNT       = 5;

   // Enable register fields.
   localparam int          PIN_INVERT_BIT    = 7;
   localparam int          PIN_ENABLE_BIT    = 6;
   localparam int          PIN_PUSHPULL_BIT  = 7;

   // Error sources summarised into the error request.
   localparam int          ERROR_SRC_W       = 5;

   localparam logic [7:0]  RESET_BYTE        = 8'h00;
   localparam logic [7:0]  READ_ZERO         = 8'h00;

endpackage : irqb_pkg

// >>> verilog/irqb_flag_bank.sv
module irqb_flag_bank #(
   parameter int WIDTH = 7
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             writeHit,
   input  wire logic             setMode,
   input  wire logic [WIDTH-1:0] writeMask,
   input  wire logic [WIDTH-1:0] hwSet,
   output logic      [WIDTH-1:0] flags_q
);

   logic [WIDTH-1:0] flags_d;

   generate
      if (WIDTH < 1 || WIDTH > 7) begin : g_bad_width
         $error("irqb_flag_bank width must lie between 1 and 7");
      end
   endgenerate

   // Hardware events are ORed in last so a set always beats a clear write.
   always_comb begin
      flags_d = flags_q;
      if (writeHit) begin
         if (setMode) begin
            flags_d = flags_q | writeMask;
         end else begin
            flags_d = flags_q & ~writeMask;
         end
      end
      flags_d = flags_d | hwSet;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

endmodule : irqb_flag_bank

// >>> verilog/irqb_request_bank.sv
// What this block does
// - Bit 7 chooses set or clear on write.
// - Only bits written one are changed.
// - FFh sets all, 7Fh clears all.
// - High watermark rise latches bit 6.
// - Low watermark rise latches bit 5.
// - Self-ended command sets command end flag.
// - Host-started idle sets no flag.
// - Transmit done sets bit 3.
// - Receive end sets bit 2.
// - Any listed error sets bit 1.
// - Frame start sets bit 0.
// - Second register writes touch bits 5..0.
// - Global flag shows any enabled request.
// - Card detection sets bit 5.
// - Timer underflows set bits 4..0.
// - Enable bits gate sources into global.
// - Pin enable gates global onto pin.
// - Invert bit flips pin level.
// - Push-pull or open-drain pin drive.
module irqb_request_bank #(
   parameter int ADDR_W = irqb_pkg::ADDR_W
) (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [7:0]        regWriteData,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output logic      [7:0]        regReadData,
   input  wire logic              highWatermarkLive,
   input  wire logic              lowWatermarkLive,
   input  wire logic              commandSelfEnd,
   input  wire logic              unknownCommandStart,
   input  wire logic              hostIdleStart,
   input  wire logic              transmitDone,
   input  wire logic              receiveEnd,
   input  wire logic              bufferWriteError,
   input  wire logic              bufferOverflowError,
   input  wire logic              protocolError,
   input  wire logic              noDataError,
   input  wire logic              integrityError,
   input  wire logic              frameStart,
   input  wire logic              cardDetect,
   input  wire logic [4:0]        timerUnderflow,
   output logic                   commandForceIdle,
   output logic                   requestPinOut,
   output logic                   requestPinOe
);

   localparam int F1 = irqb_pkg::FIRST_FLAGS_W;
   localparam int F2 = irqb_pkg::SECOND_FLAGS_W;

   generate
      if (ADDR_W < 4) begin : g_bad_addr
         $error("irqb_request_bank needs at least four address bits");
      end
   endgenerate

   logic          writeFirst;
   logic          writeSecond;
   logic          writeModeSet;
   logic [F1-1:0] firstSet;
   logic [F2-1:0] secondSet;
   logic [F1-1:0] firstFlags;
   logic [F2-1:0] secondFlags;

   logic          highWmPrev_q;
   logic          highWmPrev_d;
   logic          lowWmPrev_q;
   logic          lowWmPrev_d;
   logic [7:0]    enFirst_q;
   logic [7:0]    enFirst_d;
   logic [7:0]    enSecond_q;
   logic [7:0]    enSecond_d;
   logic          global_q;
   logic          global_d;
   logic [7:0]    readData_q;
   logic [7:0]    readData_d;
   logic          forceIdle_q;
   logic          forceIdle_d;
   logic          pinOut_q;
   logic          pinOut_d;
   logic          pinOe_q;
   logic          pinOe_d;
   logic          pinLevel;

   always_comb begin
      writeFirst   = regWrite &&
                     regAddr == ADDR_W'(irqb_pkg::ADDR_REQ_FIRST);
      writeSecond  = regWrite &&
                     regAddr == ADDR_W'(irqb_pkg::ADDR_REQ_SECOND);
      writeModeSet = regWriteData[irqb_pkg::MODE_BIT];
   end

   // Hardware set sources for the first request register.
   always_comb begin
      firstSet = '0;
      // Watermarks latch on the rising edge of the live alert level.
      firstSet[irqb_pkg::HIGH_WM_BIT] =
         highWatermarkLive & ~highWmPrev_q;
      firstSet[irqb_pkg::LOW_WM_BIT] =
         lowWatermarkLive & ~lowWmPrev_q;
      // A host-started idle never raises the flag, even if it coincides.
      firstSet[irqb_pkg::CMD_END_BIT] =
         (commandSelfEnd | unknownCommandStart) &
         ~hostIdleStart;
      firstSet[irqb_pkg::TX_DONE_BIT] = transmitDone;
      firstSet[irqb_pkg::RX_END_BIT]  = receiveEnd;
      // Held as a level so the flag re-sets while any error persists.
      firstSet[irqb_pkg::ERROR_BIT] =
         bufferWriteError | bufferOverflowError | protocolError |
         noDataError | integrityError;
      firstSet[irqb_pkg::FRAME_START_BIT] = frameStart;
   end

   always_comb begin
      secondSet = '0;
      secondSet[irqb_pkg::CARD_DETECT_BIT] = cardDetect;
      secondSet[irqb_pkg::TIMER_LOW_BIT +: irqb_pkg::TIMER_COUNT] =
         timerUnderflow;
   end

   irqb_flag_bank #(
      .WIDTH     (F1)
   ) u_first (
      .clk       (clk),
      .reset     (reset),
      .writeHit  (writeFirst),
      .setMode   (writeModeSet),
      .writeMask (regWriteData[F1-1:0]),
      .hwSet     (firstSet),
      .flags_q   (firstFlags)
   );

   // The global bit is not writable, so only bits 5..0 reach this bank.
   irqb_flag_bank #(
      .WIDTH     (F2)
   ) u_second (
      .clk       (clk),
      .reset     (reset),
      .writeHit  (writeSecond),
      .setMode   (writeModeSet),
      .writeMask (regWriteData[F2-1:0]),
      .hwSet     (secondSet),
      .flags_q   (secondFlags)
   );

   // Enable registers and the edge history of the watermark levels.
   always_comb begin
      enFirst_d    = enFirst_q;
      enSecond_d   = enSecond_q;
      highWmPrev_d = highWatermarkLive;
      lowWmPrev_d  = lowWatermarkLive;
      if (regWrite && regAddr == ADDR_W'(irqb_pkg::ADDR_EN_FIRST)) begin
         enFirst_d = regWriteData;
      end
      if (regWrite && regAddr == ADDR_W'(irqb_pkg::ADDR_EN_SECOND)) begin
         enSecond_d = regWriteData;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         enFirst_q    <= irqb_pkg::RESET_BYTE;
         enSecond_q   <= irqb_pkg::RESET_BYTE;
         highWmPrev_q <= 1'b0;
         lowWmPrev_q  <= 1'b0;
      end else begin
         enFirst_q    <= enFirst_d;
         enSecond_q   <= enSecond_d;
         highWmPrev_q <= highWmPrev_d;
         lowWmPrev_q  <= lowWmPrev_d;
      end
   end

   // Global request one flop stage behind the flags; the pin one flop stage behind global.
   always_comb begin
      global_d = |(firstFlags & enFirst_q[F1-1:0]) |
                 |(secondFlags & enSecond_q[F2-1:0]);
      pinLevel = (global_q & enSecond_q[irqb_pkg::PIN_ENABLE_BIT])
                 ^ enFirst_q[irqb_pkg::PIN_INVERT_BIT];
      if (enSecond_q[irqb_pkg::PIN_PUSHPULL_BIT]) begin
         pinOut_d = pinLevel;
         pinOe_d  = 1'b1;
      end else begin
         // Open drain only ever pulls low; high is left to the pull-up.
         pinOut_d = 1'b0;
         pinOe_d  = ~pinLevel;
      end
      forceIdle_d = unknownCommandStart;
   end

   // Read data stand only in the cycle after the read strobe.
   always_comb begin
      readData_d = irqb_pkg::READ_ZERO;
      if (regRead) begin
         unique case (regAddr)
            ADDR_W'(irqb_pkg::ADDR_REQ_FIRST):
               readData_d = {1'b0, firstFlags};
            ADDR_W'(irqb_pkg::ADDR_REQ_SECOND):
               readData_d = {1'b0, global_q, secondFlags};
            ADDR_W'(irqb_pkg::ADDR_EN_FIRST):
               readData_d = enFirst_q;
            ADDR_W'(irqb_pkg::ADDR_EN_SECOND):
               readData_d = enSecond_q;
            default:
               readData_d = irqb_pkg::READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         global_q    <= 1'b0;
         readData_q  <= irqb_pkg::READ_ZERO;
         forceIdle_q <= 1'b0;
         pinOut_q    <= 1'b0;
         pinOe_q     <= 1'b0;
      end else begin
         global_q    <= global_d;
         readData_q  <= readData_d;
         forceIdle_q <= forceIdle_d;
         pinOut_q    <= pinOut_d;
         pinOe_q     <= pinOe_d;
      end
   end

   always_comb begin
      regReadData      = readData_q;
      commandForceIdle = forceIdle_q;
      requestPinOut    = pinOut_q;
      requestPinOe     = pinOe_q;
   end

endmodule : irqb_request_bank

// >>> verification/irqb_request_bank_checker.sv
module irqb_request_bank_checker #(
   parameter int ADDR_W = 8
) (
   input wire logic              clk,
   input wire logic              reset,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [7:0]        regWriteData,
   input wire logic              regWrite,
   input wire logic              regRead,
   input wire logic [7:0]        regReadData,
   input wire logic              highWatermarkLive,
   input wire logic              lowWatermarkLive,
   input wire logic              commandSelfEnd,
   input wire logic              unknownCommandStart,
   input wire logic              hostIdleStart,
   input wire logic              transmitDone,
   input wire logic              receiveEnd,
   input wire logic              bufferWriteError,
   input wire logic              bufferOverflowError,
   input wire logic              protocolError,
   input wire logic              noDataError,
   input wire logic              integrityError,
   input wire logic              frameStart,
   input wire logic              cardDetect,
   input wire logic [4:0]        timerUnderflow,
   input wire logic              commandForceIdle,
   input wire logic              requestPinOut,
   input wire logic              requestPinOe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic       anyErr;
   logic [1:0] wm;
   assign anyErr = bufferWriteError | bufferOverflowError | protocolError
                   | noDataError | integrityError;
   assign wm = {highWatermarkLive, lowWatermarkLive};
   sequence rdFirst;
      regRead && regAddr == 8'h06;
   endsequence
   sequence rdSecond;
      regRead && regAddr == 8'h07;
   endsequence
   // Events are checked two edges back because a read returns the flags
   // that stood before its own sampling edge.
   AST_SRC_FIRST:
      assert property (rdFirst |=> &(regReadData[3:0] | ~$past({transmitDone,
         receiveEnd, anyErr, frameStart}, 2)))
      else $error("first request lost a source event");
   AST_SRC_WM:
      assert property (rdFirst |=> &(regReadData[6:5]
         | ~($past(wm, 2) & ~$past(wm, 3))))
      else $error("watermark rise not latched");
   AST_CMD_END:
      assert property (rdFirst |=> regReadData[4] || !$past((commandSelfEnd
         || unknownCommandStart) && !hostIdleStart, 2))
      else $error("command end flag not set");
   AST_SRC_SECOND:
      assert property (rdSecond |=> &(regReadData[5:0]
         | ~$past({cardDetect, timerUnderflow}, 2)))
      else $error("second request lost a source event");
   AST_MODE_ZERO:
      assert property (regRead && (regAddr == 8'h06 || regAddr == 8'h07)
         |=> !regReadData[7])
      else $error("mode bit read back as one");
   AST_FORCE_IDLE:
      assert property (unknownCommandStart |=> commandForceIdle)
      else $error("unknown command not forced to idle");
   AST_FORCE_CAUSE:
      assert property (commandForceIdle |-> $past(unknownCommandStart))
      else $error("idle forced without unknown command");
   AST_PUSHPULL_OE:
      assert property (requestPinOut |-> requestPinOe)
      else $error("pin high level driven without enable");
   AST_READ_QUIET:
      assert property (!regRead |=> regReadData == 8'h00)
      else $error("read data outside read answer cycle");
endmodule : irqb_request_bank_checker

// >>> verification/irqb_host_model.sv
module irqb_host_model (
   input  wire logic       clk,
   output logic      [7:0] regAddr,
   output logic      [7:0] regWriteData,
   output logic            regWrite,
   output logic            regRead,
   input  wire logic [7:0] regReadData
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      regAddr = 8'h00;
      regWriteData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
   end
   // Returning just after the edge lets a following cycle raise its strobe
   // in a later time step, so back-to-back access needs no idle gap.
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      regAddr <= a;
      regWriteData <= x;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] x);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 x = regReadData;
   endtask : rd
endmodule : irqb_host_model

// >>> verification/irqb_request_bank_bench.sv
module irqb_request_bank_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, reset, regWrite, regRead, unknownCommandStart, lvl;
   logic        hostIdleStart, commandForceIdle, requestPinOut, requestPinOe;
   logic [7:0]  regAddr, regWriteData, regReadData, d, e1, e2;
   logic [10:0] ev;
   logic [6:0]  f1;
   logic [5:0]  ev2, f2;
   int          n_errors, check_count, seed, b;
   irqb_host_model host (.clk(clk), .regAddr(regAddr), .regRead(regRead),
      .regWriteData(regWriteData), .regWrite(regWrite),
      .regReadData(regReadData));
   irqb_request_bank u_irqb_request_bank (.clk(clk), .reset(reset),
      .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
      .regRead(regRead), .regReadData(regReadData),
      .highWatermarkLive(ev[10]), .lowWatermarkLive(ev[9]),
      .commandSelfEnd(ev[8]), .unknownCommandStart(unknownCommandStart),
      .hostIdleStart(hostIdleStart), .transmitDone(ev[7]),
      .receiveEnd(ev[6]), .bufferWriteError(ev[1]),
      .bufferOverflowError(ev[2]), .protocolError(ev[3]),
      .noDataError(ev[4]), .integrityError(ev[5]), .frameStart(ev[0]),
      .cardDetect(ev2[5]), .timerUnderflow(ev2[4:0]),
      .commandForceIdle(commandForceIdle), .requestPinOut(requestPinOut),
      .requestPinOe(requestPinOe));
   always #20 clk = ~clk;
   task automatic checkData(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : checkData
   task automatic checkPin(input logic [1:0] got, input logic [1:0] exp);
      checkData({6'h00, got}, {6'h00, exp});
   endtask : checkPin
   task automatic complete_run;
      if (n_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick
   function automatic logic [7:0] expRd(input logic [7:0] a);
      logic g;
      g = |(f1 & e1[6:0]) | |(f2 & e2[5:0]);
      case (a)
         8'h06: return {1'b0, f1};
         8'h07: return {1'b0, g, f2};
         8'h08: return e1;
         8'h09: return e2;
         default: return 8'h00;
      endcase
   endfunction : expRd
   task automatic mwr(input logic [7:0] a, input logic [7:0] x);
      host.wr(a, x);
      if (a == 8'h06) f1 = x[7] ? (f1 | x[6:0]) : (f1 & ~x[6:0]);
      if (a == 8'h07) f2 = x[7] ? (f2 | x[5:0]) : (f2 & ~x[5:0]);
      if (a == 8'h08) e1 = x;
      if (a == 8'h09) e2 = x;
   endtask : mwr
   task automatic mrd(input logic [7:0] a);
      host.rd(a, d);
      checkData(d, expRd(a));
   endtask : mrd
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      complete_run();
   end
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      {ev, ev2, unknownCommandStart, hostIdleStart} = '0;
      {f1, f2, e1, e2, n_errors, check_count} = '0;
      seed = 32'h4F7F;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      tick();
      for (int a = 6; a < 11; a++) mrd(8'(a));
      repeat (24) begin
         mwr({7'h03, 1'($random(seed))},
             8'($random(seed)));
         mrd(8'h06);
         mrd(8'h07);
      end
      mwr(8'h06, 8'hFF);
      mrd(8'h06);
      mwr(8'h06, 8'h7F);
      mrd(8'h06);
      mwr(8'h07, 8'h3F);
      for (int i = 0; i < 11; i++) begin
         ev[i] <= 1'b1;
         tick();
         ev <= '0;
         b = (i == 0) ? 0 : (i < 6) ? 1 : i - 4;
         f1[b] = 1'b1;
         mrd(8'h06);
         mwr(8'h06, 8'h7F);
      end
      for (int i = 0; i < 6; i++) begin
         ev2[i] <= 1'b1;
         tick();
         ev2 <= '0;
         f2[i] = 1'b1;
         mrd(8'h07);
         mwr(8'h07, 8'h3F);
      end
      unknownCommandStart <= 1'b1;
      tick();
      unknownCommandStart <= 1'b0;
      checkData({7'h00, commandForceIdle}, 8'h01);
      f1[4] = 1'b1;
      mrd(8'h06);
      mwr(8'h06, 8'h10);
      hostIdleStart <= 1'b1;
      ev[8] <= 1'b1;
      tick();
      hostIdleStart <= 1'b0;
      ev <= '0;
      mrd(8'h06);
      ev[7] <= 1'b1;
      mwr(8'h06, 8'h08);
      ev <= '0;
      f1[3] = 1'b1;
      mrd(8'h06);
      for (int k = 0; k < 16; k++) begin
         mwr(8'h08, {k[0], 3'h0, k[1], 3'h0});
         mwr(8'h09, {k[2], k[3], 6'h00});
         mrd(8'h08);
         mrd(8'h09);
         mrd(8'h07);
         lvl = (k[1] & k[3]) ^ k[0];
         checkPin({requestPinOut, requestPinOe},
                  k[2] ? {lvl, 1'b1} : {1'b0, ~lvl});
      end
      complete_run();
   end
endmodule : irqb_request_bank_bench
bind irqb_request_bank irqb_request_bank_checker #(.ADDR_W(ADDR_W))
   u_checker (.*);
